// File: hdl/standby_pkg.sv
// shared types and constants for the standby mode controller
`default_nettype none
package standby_pkg;

  // low-power state requested by the core
  typedef enum logic [1:0] {
    REQ_NONE,
    REQ_HALT,
    REQ_HOLD,
    REQ_XHOLD
  } standbyReq_t;

  // detection kinds for external lines a and b
  typedef enum logic [2:0] {
    DET_RISE,
    DET_FALL,
    DET_HIGH,
    DET_LOW,
    DET_BOTH
  } detKind_t;

  // oscillator run controls, one bit per source
  typedef struct packed {
    logic ceramicRun;
    logic slowRcRun;
    logic medRcRun;
    logic varRcRun;
    logic crystalRun;
  } oscCtl_t;

  // wake sources as seen by the block
  typedef struct packed {
    logic extResetLow;
    logic lvdReset;
    logic wdtReset;
    logic irqAccepted;
    logic lineA;
    logic lineB;
    logic lineC;
    logic lineE;
    logic lineF;
    logic port0Irq;
    logic baseTimerIrq;
  } wakeSrc_t;

  // oscillator state after reset: everything stopped but slow rc
  localparam oscCtl_t OSC_RESET = '{
    ceramicRun: 1'b0, slowRcRun: 1'b1, medRcRun: 1'b0,
    varRcRun: 1'b0, crystalRun: 1'b0};

endpackage : standby_pkg
`default_nettype wire

// File: hdl/standby_mode_controller.sv
// standby mode controller: halt, deep suspend and crystal-retaining suspend
`default_nettype none
module standby_mode_controller
  import standby_pkg::*;
(
  input  wire logic        clk,            // 40 MHz system clock
  input  wire logic        rst_n,          // async reset, active low
  input  wire standbyReq_t entryReq,       // core entry request, same domain
  input  wire oscCtl_t     oscCmd,         // software oscillator settings
  input  wire logic        crystalSelected,// crystal is the chosen source
  input  wire logic        wdtSlowRcCtl,   // watchdog keeps slow rc running in both suspends
  input  wire detKind_t    lineADet,       // detection kind, line a
  input  wire detKind_t    lineBDet,       // detection kind, line b
  input  wire wakeSrc_t    wakeRaw,        // wake sources from pins/logic
  output var oscCtl_t      oscRun,         // oscillator run enables
  output logic             cpuHalted,      // instruction execution stopped
  output logic             periphStopped,  // peripheral clocks gated
  output logic             baseTimerRun,   // base timer clock enabled
  output logic             resumeIrq,      // pulse: resume via interrupt
  output logic             resetRequest    // pulse: take reset sequence
);

  typedef enum {ST_RUN, ST_HALT, ST_HOLD, ST_XHOLD} mode_t;

  // two-stage synchronisers for outside wake sources
  wakeSrc_t wakeMeta_q;                     // first stage, read only by second
  wakeSrc_t wake_q;                         // synchronised sources
  mode_t    mode_q, mode_d;                 // current standby state
  logic     lineAWake, lineBWake;           // qualified lines a and b
  logic     anyReset;                       // any system reset cause
  logic     suspendIrq;                     // suspend-capable interrupt
  logic     wakeIrq, wakeRst;               // wake decision of this cycle
  logic     crystalAtEntry_q;               // crystal state latched on entry

  // synchronise wake inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeMeta_q <= '0;
      wake_q     <= '0;
    end else begin
      wakeMeta_q <= wakeRaw;
      wake_q     <= wakeMeta_q;
    end
  end

  // lines a and b only qualify for suspend wake in level mode
  always_comb begin
    // edge kinds and the unsupported both-edge code never wake a suspend
    lineAWake = wake_q.lineA
                && (lineADet == DET_HIGH || lineADet == DET_LOW);
    lineBWake = wake_q.lineB
                && (lineBDet == DET_HIGH || lineBDet == DET_LOW);
    anyReset  = wake_q.extResetLow || wake_q.lvdReset || wake_q.wdtReset;
    suspendIrq = lineAWake || lineBWake || wake_q.lineC || wake_q.lineE
                 || wake_q.lineF || wake_q.port0Irq;
  end

  // wake decision per state
  always_comb begin
    wakeRst = 1'b0;
    wakeIrq = 1'b0;
    case (mode_q)
      ST_HALT: begin
        wakeRst = anyReset;
        wakeIrq = !anyReset && wake_q.irqAccepted;
      end
      ST_HOLD: begin
        wakeRst = anyReset;
        wakeIrq = !anyReset && suspendIrq;
      end
      ST_XHOLD: begin
        wakeRst = anyReset;
        wakeIrq = !anyReset && (suspendIrq
                  || (wake_q.baseTimerIrq && crystalSelected));
      end
      default: begin
        wakeRst = 1'b0;
        wakeIrq = 1'b0;
      end
    endcase
  end

  // next state
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ST_RUN: begin
        case (entryReq)
          REQ_HALT:  mode_d = ST_HALT;
          REQ_HOLD:  mode_d = ST_HOLD;
          REQ_XHOLD: mode_d = ST_XHOLD;
          default:   mode_d = ST_RUN;
        endcase
      end
      ST_HALT, ST_HOLD, ST_XHOLD: begin
        if (wakeRst || wakeIrq) mode_d = ST_RUN;
      end
      default: mode_d = ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode_q <= ST_RUN;
    else        mode_q <= mode_d;
  end

  // crystal run state captured at crystal-suspend entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) crystalAtEntry_q <= 1'b0;
    else if (mode_q == ST_RUN && mode_d == ST_XHOLD)
      crystalAtEntry_q <= oscCmd.crystalRun;
  end

  // oscillator enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oscRun <= OSC_RESET;
    else begin
      case (mode_d)
        ST_HOLD: begin
          oscRun            <= '0;
          oscRun.slowRcRun  <= wdtSlowRcCtl;
        end
        ST_XHOLD: begin
          oscRun            <= '0;
          oscRun.slowRcRun  <= wdtSlowRcCtl;
          oscRun.crystalRun <= (mode_q == ST_XHOLD) ? crystalAtEntry_q
                               : oscCmd.crystalRun;
        end
        // halt and run follow software settings untouched
        default: oscRun <= oscCmd;
      endcase
    end
  end

  // execution and peripheral gating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuHalted     <= 1'b0;
      periphStopped <= 1'b0;
      baseTimerRun  <= 1'b1;
    end else begin
      cpuHalted     <= (mode_d != ST_RUN);
      periphStopped <= (mode_d == ST_HOLD) || (mode_d == ST_XHOLD);
      baseTimerRun  <= (mode_d != ST_HOLD);
    end
  end

  // wake outcome pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resumeIrq    <= 1'b0;
      resetRequest <= 1'b0;
    end else begin
      resumeIrq    <= wakeIrq;
      resetRequest <= wakeRst;
    end
  end

  // assertions
  a_halt_osc_kept: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_HALT && $past(mode_q) == ST_HALT |-> oscRun == $past(oscCmd))
    else $error("halt changed oscillators");
  a_hold_osc_off: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_HOLD |-> !oscRun.ceramicRun && !oscRun.crystalRun
      && !oscRun.medRcRun && !oscRun.varRcRun)
    else $error("hold left an oscillator on");
  a_halt_irq_wake: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_HALT && wake_q.irqAccepted && !anyReset |=> mode_q == ST_RUN && resumeIrq)
    else $error("halt missed interrupt wake");
  a_reset_wake: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q != ST_RUN && anyReset |=> resetRequest && mode_q == ST_RUN)
    else $error("reset did not wake");
  a_edge_no_wake: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_HOLD && !anyReset && !lineBWake && !wake_q.lineC && !wake_q.lineE
      && !wake_q.lineF && !wake_q.port0Irq && lineADet inside {DET_RISE, DET_FALL}
      |=> mode_q == ST_HOLD)
    else $error("edge line woke suspend");
  a_port0_wake: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == ST_HOLD || mode_q == ST_XHOLD) && wake_q.port0Irq |=> mode_q == ST_RUN)
    else $error("port 0 did not wake");
  a_base_timer_wake: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_XHOLD && !anyReset && !suspendIrq && wake_q.baseTimerIrq
      |=> (mode_q == ST_RUN) == $past(crystalSelected))
    else $error("base timer wake wrong");
  a_xhold_periph: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_XHOLD |-> cpuHalted && periphStopped && baseTimerRun)
    else $error("crystal suspend gating wrong");
  a_xhold_crystal: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_XHOLD && $past(mode_q) == ST_XHOLD |-> oscRun.crystalRun == crystalAtEntry_q)
    else $error("crystal state not kept");
  a_slow_rc_wdt: assert property (@(posedge clk) disable iff (!rst_n)
    mode_q inside {ST_HOLD, ST_XHOLD} |-> oscRun.slowRcRun == $past(wdtSlowRcCtl))
    else $error("slow rc not under watchdog");

  c_halt_wake: cover property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_HALT ##1 resumeIrq);
  c_hold_wake: cover property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_HOLD ##1 resumeIrq);
  c_xhold_timer: cover property (@(posedge clk) disable iff (!rst_n)
    mode_q == ST_XHOLD && wake_q.baseTimerIrq ##1 resumeIrq);
  c_reset_wake: cover property (@(posedge clk) disable iff (!rst_n)
    mode_q != ST_RUN ##1 resetRequest);

endmodule : standby_mode_controller
`default_nettype wire

// File: tb/wake_source_model.sv
// wake source model: raises one source, drops all once served
`default_nettype none
module wake_source_model
  import standby_pkg::*;
(
  input  wire logic       clk,          // system clock
  input  wire logic       rst_n,        // async reset, active low
  input  wire logic       fire,         // raise the chosen source
  input  wire logic [3:0] fireIdx,      // bit index in wakeSrc_t
  input  wire logic       resumeIrq,    // interrupt wake answered
  input  wire logic       resetRequest, // reset wake answered
  output var  wakeSrc_t   wakeRaw       // level wake sources
);
  timeunit 1ns;
  timeprecision 1ps;
  // a source stays pending until the device answers it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeRaw <= '0;
    end else if (resumeIrq || resetRequest) begin
      wakeRaw <= '0; // served, withdraw
    end else if (fire) begin
      wakeRaw[fireIdx] <= 1'b1;
    end
  end
endmodule : wake_source_model
`default_nettype wire

// File: tb/test_standby_mode_controller.sv
// self-checking bench for the standby mode controller
`default_nettype none
module test_standby_mode_controller
  import standby_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, crystalSelected, wdtSlowRcCtl, fire; // bench drives
  logic        cpuHalted, periphStopped, baseTimerRun, resumeIrq, resetRequest;
  logic [3:0]  fireIdx;   // source to raise
  standbyReq_t entryReq;  // core request
  oscCtl_t     oscCmd;    // software oscillator settings
  oscCtl_t     oscRun;    // oscillator enables seen
  detKind_t    lineADet;  // line a detection
  detKind_t    lineBDet;  // line b detection
  wakeSrc_t    wakeRaw;   // model to device
  logic [1:0]  expQ[$];   // expected pulse: 1 resume, 2 reset
  int          seed = 27050;
  int          err_total = 0;
  int          checks = 0;

  standby_mode_controller i_dut (.clk(clk), .rst_n(rst_n), .entryReq(entryReq),
    .oscCmd(oscCmd), .crystalSelected(crystalSelected), .wdtSlowRcCtl(wdtSlowRcCtl),
    .lineADet(lineADet), .lineBDet(lineBDet), .wakeRaw(wakeRaw), .oscRun(oscRun),
    .cpuHalted(cpuHalted), .periphStopped(periphStopped), .baseTimerRun(baseTimerRun),
    .resumeIrq(resumeIrq), .resetRequest(resetRequest));
  wake_source_model i_src (.clk(clk), .rst_n(rst_n), .fire(fire), .fireIdx(fireIdx),
    .resumeIrq(resumeIrq), .resetRequest(resetRequest), .wakeRaw(wakeRaw));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one comparison, counted
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // verdict and end of run
  task automatic close_out();
    check("pending", 8'd0, 8'(expQ.size()));
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // every wake pulse takes the oldest note
  always @(negedge clk) begin
    if (rst_n && (resumeIrq === 1'b1 || resetRequest === 1'b1)) begin
      if (expQ.size() == 0) begin
        check("pulse", 8'd0, {6'd0, resetRequest, resumeIrq});
      end else begin
        check("pulse", 8'(expQ.pop_front()), {6'd0, resetRequest, resumeIrq});
      end
    end
  end

  // enter a state, raise one source; res 0 means it must not wake
  task automatic run_case(input standbyReq_t req, input logic [3:0] idx,
                          input logic [1:0] res, input detKind_t det, input logic xSel);
    oscCtl_t expOsc;
    int      n;
    @(posedge clk);
    oscCmd <= oscCtl_t'(5'($random(seed)));
    wdtSlowRcCtl <= 1'($random(seed));
    lineADet <= det;
    lineBDet <= det;
    crystalSelected <= xSel;
    @(posedge clk);
    entryReq <= req;
    @(posedge clk);
    entryReq <= REQ_NONE;
    @(negedge clk);
    // halt keeps software settings; suspends set slow rc from wdtSlowRcCtl and, in crystal hold, keep crystal
    expOsc = '0;
    expOsc.slowRcRun = wdtSlowRcCtl;
    expOsc.crystalRun = (req == REQ_XHOLD) && oscCmd.crystalRun;
    if (req == REQ_HALT) expOsc = oscCmd;
    check("oscRun", 8'(expOsc), 8'(oscRun));
    check("cpuHalted", 8'd1, 8'(cpuHalted));
    check("periphStopped", 8'(req != REQ_HALT), 8'(periphStopped));
    check("baseTimerRun", 8'(req != REQ_HOLD), 8'(baseTimerRun));
    @(posedge clk);
    fireIdx <= idx;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    if (res == 2'd0) begin
      repeat (8) @(negedge clk);
      check("stillAsleep", 8'd1, 8'(cpuHalted));
      @(posedge clk);
      fireIdx <= 4'd10;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      res = 2'd2;
    end
    expQ.push_back(res);
    n = 0;
    while (cpuHalted !== 1'b0 && n < 12) begin
      @(negedge clk);
      n++;
    end
    check("woken", 8'd0, 8'(cpuHalted));
    if (res == 2'd1) check("oscRestart", 8'(oscCmd), 8'(oscRun));
    $display("test done: state %0d source %0d", req, idx);
  endtask : run_case

  // main sequence
  initial begin
    logic [1:0] wantRes; // expected outcome of a wake case
    detKind_t   edgeDet; // non-level detection kind under test
    rst_n = 1'b0;
    entryReq = REQ_NONE;
    oscCmd = OSC_RESET;
    {crystalSelected, wdtSlowRcCtl, fire} = 3'b000;
    fireIdx = 4'd0;
    lineADet = DET_HIGH;
    lineBDet = DET_HIGH;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("oscReset", 8'(OSC_RESET), 8'(oscRun));
    check("haltReset", 8'd0, 8'(cpuHalted));
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 7; i <= 10; i++) begin
      wantRes = (i == 7) ? 2'd1 : 2'd2;
      run_case(REQ_HALT, 4'(i), wantRes, DET_HIGH, 1'b0);
    end
    for (int i = 0; i <= 10; i++) begin
      if (i != 7) begin
        wantRes = (i > 7) ? 2'd2 : 2'd1;
        run_case(REQ_XHOLD, 4'(i), wantRes, DET_HIGH, 1'b1);
        if (i == 0) wantRes = 2'd0;
        run_case(REQ_HOLD, 4'(i), wantRes, DET_LOW, 1'b1);
      end
    end
    run_case(REQ_XHOLD, 4'd0, 2'd0, DET_HIGH, 1'b0);
    // rising, falling and the unsupported both-edge code must all stay asleep
    for (int d = 0; d < 3; d++) begin
      edgeDet = (d == 2) ? DET_BOTH : detKind_t'(d);
      run_case(REQ_HOLD, 4'd6, 2'd0, edgeDet, 1'b0);
      run_case(REQ_XHOLD, 4'd5, 2'd0, edgeDet, 1'b0);
    end
    repeat (5) @(posedge clk);
    close_out();
  end

  // watchdog against a hang
  initial begin
    #(25ns * 4000);
    err_total++;
    close_out();
  end
endmodule : test_standby_mode_controller
`default_nettype wire
